// ===== hdl/io_channel_config_defines.vh
// constants for the channel configuration register bank
// assumes a 100 MHz clk_i and a host that frames serial words with a low-active sync
`ifndef IO_CHANNEL_CONFIG_DEFINES_VH
`define IO_CHANNEL_CONFIG_DEFINES_VH

// --------------------------------------------------------------------
// register addresses
// --------------------------------------------------------------------
`define ADDR_NO_OPERATION 7'h00
`define ADDR_CHANNEL_FUNCTION 7'h01
`define ADDR_CONVERTER 7'h02
`define ADDR_POWER_SAVING 7'h03
`define ADDR_LOGIC_INPUT_A 7'h04
`define ADDR_LOGIC_INPUT_B 7'h05
`define ADDR_OUTPUT 7'h06
`define ADDR_WIRING 7'h07
`define ADDR_INT_SWITCH 7'h08
`define ADDR_EXT_SWITCH 7'h09
`define ADDR_OPEN_WIRE 7'h0A
`define ADDR_OUTPUT_CODE 7'h0B
`define ADDR_OUTPUT_CODE_LIVE 7'h0D
`define ADDR_PIN_FIRST 7'h35
`define ADDR_PIN_LAST 7'h38
`define ADDR_LEAKAGE 7'h39
`define ADDR_BOOST 7'h3A
`define ADDR_CONVERSION 7'h3B
`define ADDR_DIAGNOSTIC 7'h3C

// --------------------------------------------------------------------
// storage indices and reset values
// --------------------------------------------------------------------
`define CFG_COUNT 11
`define CTL_COUNT 4
`define PIN_COUNT 4
`define IDX_CHANNEL_FUNCTION 4'h0
`define IDX_CONVERTER 4'h1
`define IDX_LOGIC_INPUT_A 4'h3
`define IDX_LOGIC_INPUT_B 4'h4
`define IDX_OUTPUT 4'h5
`define IDX_WIRING 4'h6
`define IDX_OUTPUT_CODE 4'hA
`define IDX_BOOST 2'h1
`define IDX_CONVERSION 2'h2
`define IDX_DIAGNOSTIC 2'h3
`define RST_ZERO 16'h0000
`define RST_CONVERTER 16'h2400
`define RST_POWER_SAVING 16'h001F
`define RST_LOGIC_INPUT_A 16'h000B
`define RST_WIRING 16'h0001
`define RST_SWITCH 16'h2E00
`define RST_PIN 5'h08

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define PIN_MODE_MSB 2
`define PIN_PULLDOWN_BIT 3
`define PIN_LEVEL_OUT_BIT 4
`define PIN_MODE_DRIVE 3'h1
`define PIN_RSVD_WIDTH 10
`define BOOST_ENABLE_BIT 0
`define OUTPUT_SLEW_EN_BIT 6

// --------------------------------------------------------------------
// serial frame
// --------------------------------------------------------------------
`define FRAME_BITS 6'h20
`define FRAME_READ_BIT 31
`define FRAME_ADDR_MSB 30
`define FRAME_ADDR_LSB 24
`define FRAME_DATA_MSB 23
`define FRAME_DATA_LSB 8
`define FRAME_TAIL 8'h00
`define FRAME_COUNT_MAX 6'h3F

// --------------------------------------------------------------------
// slew timing
// --------------------------------------------------------------------
// reload for a 1000 ns step at a 10 ns clock: 100 cycles counted down to zero
`define SLEW_RELOAD 16'h0063
`define SLEW_STEP_CODE 16'h0001

`endif

// ===== hdl/io_channel_config_regs.v
// configuration register bank of one software configurable i/o channel
// assumes sclk idles high, host samples sdo on falling sclk, sclk at most clk_i/8
`timescale 1ns/1ps
`include "io_channel_config_defines.vh"

module io_channel_config_regs (
   input wire clk_i,
   input wire reset_i,
   input wire sclk_i,
   input wire sync_n_i,
   input wire sdi_i,
   output reg sdo_o,
   input wire [3:0] pin_i,
   output wire [3:0] pin_o,
   output wire [3:0] pin_oe_o,
   output wire [3:0] pin_pulldown_en_o,
   output wire [15:0] channel_function_o,
   output wire [15:0] converter_settings_o,
   output wire [15:0] conversion_control_o,
   output wire [15:0] diagnostic_source_select_o,
   output wire boost_supply_en_o,
   output reg [15:0] output_code_live_o,
   output reg frame_ignored_o
);

   // --------------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------------
   // sclk and sync reset to their idle high level, so release is no false edge;
   // the third flop only feeds the edge detectors below
   reg sclk_s1;
   reg sclk_s2;
   reg sclk_s3;
   reg sync_s1;
   reg sync_s2;
   reg sync_s3;
   reg sdi_s1;
   reg sdi_s2;
   reg [3:0] pin_s1;
   reg [3:0] pin_s2;

   always @(posedge clk_i) begin
      if (reset_i) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         sync_s1 <= 1'b1;
         sync_s2 <= 1'b1;
         sync_s3 <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end else begin
         sclk_s1 <= sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sync_s1 <= sync_n_i;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
         sdi_s1 <= sdi_i;
         sdi_s2 <= sdi_s1;
         pin_s1 <= pin_i;
         pin_s2 <= pin_s1;
      end
   end

   // edges are seen a few clocks late; the host keeps sclk slow enough for that
   wire frame_active = ~sync_s2;
   wire frame_start = sync_s3 & ~sync_s2;
   wire frame_end = ~sync_s3 & sync_s2;
   wire sclk_fall = sclk_s3 & ~sclk_s2;
   wire sclk_rise = ~sclk_s3 & sclk_s2;

   // --------------------------------------------------------------------
   // frame receiver
   // --------------------------------------------------------------------
   reg [5:0] bit_count;
   reg [31:0] rx_shift;
   reg [31:0] tx_shift;
   reg [6:0] read_addr;
   reg wr_en;
   reg [6:0] wr_addr;
   reg [15:0] wr_data;
   reg [15:0] read_data;

   // --------------------------------------------------------------------
   // frame word fields
   // --------------------------------------------------------------------
   // the last 32 bits shifted in; longer frames are refused by the count
   wire frame_is_read = rx_shift[`FRAME_READ_BIT];
   wire [6:0] frame_addr = rx_shift[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
   wire [15:0] frame_data = rx_shift[`FRAME_DATA_MSB:`FRAME_DATA_LSB];
   wire frame_count_ok = (bit_count == `FRAME_BITS);
   // readback word: address, data, tail; a leading zero goes out before it
   wire [31:0] tx_word = {read_addr, read_data, `FRAME_TAIL, 1'b0};

   always @(posedge clk_i) begin
      if (reset_i) begin
         bit_count <= 6'h00;
         rx_shift <= 32'h00000000;
         tx_shift <= 32'h00000000;
         read_addr <= `ADDR_NO_OPERATION;
         wr_en <= 1'b0;
         wr_addr <= `ADDR_NO_OPERATION;
         wr_data <= `RST_ZERO;
         frame_ignored_o <= 1'b0;
         sdo_o <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         frame_ignored_o <= 1'b0;
         if (frame_start) begin
            bit_count <= 6'h00;
            sdo_o <= 1'b0;
            tx_shift <= tx_word;
         end else if (frame_active) begin
            if (sclk_fall) begin
               rx_shift <= {rx_shift[30:0], sdi_s2};
               // count saturates so a very long frame never wraps back to 32
               if (bit_count != `FRAME_COUNT_MAX) begin
                  bit_count <= bit_count + 6'h01;
               end
            end
            // sdo moves on rising sclk so it is settled at the host's falling sample
            if (sclk_rise) begin
               sdo_o <= tx_shift[31];
               tx_shift <= {tx_shift[30:0], 1'b0};
            end
         end
         if (frame_end) begin
            sdo_o <= 1'b0;
            if (!frame_count_ok) begin
               frame_ignored_o <= 1'b1;
            end else if (frame_is_read) begin
               // only the address is latched; its data leaves in the next frame
               read_addr <= frame_addr;
            end else begin
               wr_en <= 1'b1;
               wr_addr <= frame_addr;
               wr_data <= frame_data;
            end
         end
      end
   end

   // --------------------------------------------------------------------
   // configuration storage 0x01 to 0x0B and 0x39 to 0x3C
   // --------------------------------------------------------------------
   reg [15:0] cfg [0:`CFG_COUNT-1];
   reg [15:0] ctl [0:`CTL_COUNT-1];
   wire [6:0] cfg_off = wr_addr - `ADDR_CHANNEL_FUNCTION;
   wire [6:0] ctl_off = wr_addr - `ADDR_LEAKAGE;
   wire [6:0] rd_cfg_off = read_addr - `ADDR_CHANNEL_FUNCTION;
   wire [6:0] rd_ctl_off = read_addr - `ADDR_LEAKAGE;
   wire [6:0] rd_pin_off = read_addr - `ADDR_PIN_FIRST;
   integer i;

   function [15:0] cfg_reset;
      input [3:0] idx;
      begin
         case (idx)
            4'h1: cfg_reset = `RST_CONVERTER;
            4'h2: cfg_reset = `RST_POWER_SAVING;
            4'h3: cfg_reset = `RST_LOGIC_INPUT_A;
            4'h6: cfg_reset = `RST_WIRING;
            4'h7: cfg_reset = `RST_SWITCH;
            4'h8: cfg_reset = `RST_SWITCH;
            default: cfg_reset = `RST_ZERO;
         endcase
      end
   endfunction

   // --------------------------------------------------------------------
   // write decode
   // --------------------------------------------------------------------
   // address zero decodes to nothing, so a write there changes no state
   wire wr_cfg_hit = (wr_addr != `ADDR_NO_OPERATION) && (wr_addr <= `ADDR_OUTPUT_CODE);
   wire wr_function = (wr_addr == `ADDR_CHANNEL_FUNCTION);
   wire wr_ctl_hit = (wr_addr >= `ADDR_LEAKAGE) && (wr_addr <= `ADDR_DIAGNOSTIC);

   always @(posedge clk_i) begin
      if (reset_i) begin
         for (i = 0; i < `CFG_COUNT; i = i + 1) begin
            cfg[i] <= cfg_reset(i[3:0]);
         end
         for (i = 0; i < `CTL_COUNT; i = i + 1) begin
            ctl[i] <= `RST_ZERO;
         end
      end else if (wr_en) begin
         if (wr_cfg_hit) begin
            cfg[cfg_off[3:0]] <= wr_data;
            if (wr_function) begin
               cfg[`IDX_CONVERTER] <= cfg_reset(`IDX_CONVERTER);
               cfg[`IDX_LOGIC_INPUT_A] <= cfg_reset(`IDX_LOGIC_INPUT_A);
               cfg[`IDX_LOGIC_INPUT_B] <= cfg_reset(`IDX_LOGIC_INPUT_B);
               cfg[`IDX_OUTPUT] <= cfg_reset(`IDX_OUTPUT);
               cfg[`IDX_WIRING] <= cfg_reset(`IDX_WIRING);
               cfg[`IDX_OUTPUT_CODE] <= cfg[`IDX_OUTPUT_CODE];
            end
         end else if (wr_ctl_hit) begin
            ctl[ctl_off[1:0]] <= wr_data;
         end
      end
   end

   // storage leaves as is, boost as its enable bit 0 alone; the analog side decodes the fields
   assign channel_function_o = cfg[`IDX_CHANNEL_FUNCTION];
   assign converter_settings_o = cfg[`IDX_CONVERTER];
   assign conversion_control_o = ctl[`IDX_CONVERSION];
   assign diagnostic_source_select_o = ctl[`IDX_DIAGNOSTIC];
   assign boost_supply_en_o = ctl[`IDX_BOOST][`BOOST_ENABLE_BIT];

   // --------------------------------------------------------------------
   // live output code with slewing
   // --------------------------------------------------------------------
   reg [15:0] slew_count;
   wire [15:0] target_code = cfg[`IDX_OUTPUT_CODE];
   wire slew_on = cfg[`IDX_OUTPUT][`OUTPUT_SLEW_EN_BIT];
   wire slew_tick = (slew_count == 16'h0000);

   always @(posedge clk_i) begin
      if (reset_i) begin
         slew_count <= 16'h0000;
         output_code_live_o <= `RST_ZERO;
      end else begin
         if (slew_tick) begin
            slew_count <= `SLEW_RELOAD;
         end else begin
            slew_count <= slew_count - 16'h0001;
         end
         // with slew off the live code follows the target one clock later;
         // with slew on it moves one code per tick, so large changes take long
         // loaded code or slew step
         if (!slew_on) begin
            output_code_live_o <= target_code;
         end else if (slew_tick && output_code_live_o < target_code) begin
            output_code_live_o <= output_code_live_o + `SLEW_STEP_CODE;
         end else if (slew_tick && output_code_live_o > target_code) begin
            output_code_live_o <= output_code_live_o - `SLEW_STEP_CODE;
         end
      end
   end

   // --------------------------------------------------------------------
   // general-purpose pins
   // --------------------------------------------------------------------
   wire [15:0] pin_readback [0:`PIN_COUNT-1];

   genvar g;
   generate
      for (g = 0; g < `PIN_COUNT; g = g + 1) begin : gen_pin
         reg [4:0] pin_cfg;
         always @(posedge clk_i) begin
            if (reset_i) begin
               pin_cfg <= `RST_PIN;
            end else if (wr_en && wr_addr == `ADDR_PIN_FIRST + g) begin
               pin_cfg <= wr_data[`PIN_LEVEL_OUT_BIT:0];
            end
         end
         // the enable follows the mode field alone, so a mode change acts at once
         // drive in mode 001
         assign pin_oe_o[g] = (pin_cfg[`PIN_MODE_MSB:0] == `PIN_MODE_DRIVE);
         assign pin_o[g] = pin_cfg[`PIN_LEVEL_OUT_BIT];
         assign pin_pulldown_en_o[g] = pin_cfg[`PIN_PULLDOWN_BIT];
         // only bits 4:0 are stored; bit 5 is the synchronised pin
         // sensed level, reserved zero
         assign pin_readback[g] = {{`PIN_RSVD_WIDTH{1'b0}}, pin_s2[g], pin_cfg};
      end
   endgenerate

   // --------------------------------------------------------------------
   // read decode
   // --------------------------------------------------------------------
   // unmapped holes fall through and read as zero
   wire rd_cfg_hit = (read_addr != `ADDR_NO_OPERATION) && (read_addr <= `ADDR_OUTPUT_CODE);
   wire rd_live_hit = (read_addr == `ADDR_OUTPUT_CODE_LIVE);
   wire rd_pin_hit = (read_addr >= `ADDR_PIN_FIRST) && (read_addr <= `ADDR_PIN_LAST);
   wire rd_ctl_hit = (read_addr >= `ADDR_LEAKAGE) && (read_addr <= `ADDR_DIAGNOSTIC);

   // --------------------------------------------------------------------
   // readback selection
   // --------------------------------------------------------------------
   always @* begin
      read_data = `RST_ZERO;
      if (rd_cfg_hit) begin
         read_data = cfg[rd_cfg_off[3:0]];
      end else if (rd_live_hit) begin
         read_data = output_code_live_o;
      end else if (rd_pin_hit) begin
         read_data = pin_readback[rd_pin_off[1:0]];
      end else if (rd_ctl_hit) begin
         read_data = ctl[rd_ctl_off[1:0]];
      end
   end

endmodule // io_channel_config_regs

// ===== test/io_channel_config_checker_assertions.sv
// assertion checker for the channel configuration register bank
// assumes the host moves sync_n_i only on clk_i rising edges
`timescale 1ns/1ps
module io_channel_config_checker (
   input wire clk_i,
   input wire reset_i,
   input wire sclk_i,
   input wire sync_n_i,
   input wire sdi_i,
   input wire sdo_o,
   input wire [3:0] pin_i,
   input wire [3:0] pin_o,
   input wire [3:0] pin_oe_o,
   input wire [3:0] pin_pulldown_en_o,
   input wire [15:0] channel_function_o,
   input wire [15:0] converter_settings_o,
   input wire [15:0] conversion_control_o,
   input wire [15:0] diagnostic_source_select_o,
   input wire boost_supply_en_o,
   input wire [15:0] output_code_live_o,
   input wire frame_ignored_o
);
   // ----
   // cycles since frame end, idle length
   // ----
   logic [7:0] since_end;
   logic [3:0] idle_cnt;
   logic sync_last;
   always @(posedge clk_i) begin
      if (reset_i) begin
         since_end <= 8'hFF;
         idle_cnt <= 4'h0;
         sync_last <= 1'b1;
      end else begin
         sync_last <= sync_n_i;
         if (sync_n_i && !sync_last)
            since_end <= 8'h00;
         else if (since_end != 8'hFF)
            since_end <= since_end + 8'h01;
         if (!sync_n_i)
            idle_cnt <= 4'h0;
         else if (idle_cnt != 4'hF)
            idle_cnt <= idle_cnt + 4'h1;
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_quiet;
      ($stable(diagnostic_source_select_o) && $stable(converter_settings_o)) [*5];
   endsequence
   a_ignored_no_write: assert property (frame_ignored_o |-> s_quiet)
      else $error("ignored frame wrote");
   a_ignore_single_pulse: assert property (frame_ignored_o |=> !frame_ignored_o)
      else $error("ignore pulse too long");
   a_ignore_at_end: assert property (frame_ignored_o |-> since_end <= 8'h0C)
      else $error("ignore pulse away from frame end");
   a_config_only_written: assert property (since_end > 8'h0C |-> $stable({channel_function_o,
      converter_settings_o, conversion_control_o, diagnostic_source_select_o, boost_supply_en_o}))
      else $error("config changed without frame");
   a_pins_only_written: assert property (since_end > 8'h0C |->
      $stable({pin_o, pin_oe_o, pin_pulldown_en_o})) else $error("pin control changed");
   a_live_slew_step: assert property ($changed(output_code_live_o) && since_end > 8'h0C |->
      (output_code_live_o - $past(output_code_live_o) == 16'h0001) ||
      ($past(output_code_live_o) - output_code_live_o == 16'h0001)) else $error("live jump");
   a_reset_pin_defaults: assert property ($fell(reset_i) |-> pin_pulldown_en_o == 4'hF &&
      pin_oe_o == 4'h0 && converter_settings_o == 16'h2400 && !boost_supply_en_o)
      else $error("bad reset defaults");
   a_function_reload: assert property ($changed(channel_function_o) |->
      ##[0:2] converter_settings_o == 16'h2400) else $error("no reload on function");
   a_sdo_idle_low: assert property (idle_cnt == 4'hF |-> !sdo_o)
      else $error("sdo active outside frame");
endmodule // io_channel_config_checker

bind io_channel_config_regs io_channel_config_checker chk (.clk_i(clk_i), .reset_i(reset_i),
   .sclk_i(sclk_i), .sync_n_i(sync_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pulldown_en_o(pin_pulldown_en_o),
   .channel_function_o(channel_function_o), .converter_settings_o(converter_settings_o),
   .conversion_control_o(conversion_control_o), .boost_supply_en_o(boost_supply_en_o),
   .diagnostic_source_select_o(diagnostic_source_select_o),
   .output_code_live_o(output_code_live_o), .frame_ignored_o(frame_ignored_o));

// ===== test/io_channel_host_model.sv
// host model driving serial frames into the register bank
// assumes clk_i at 100 MHz; sclk half period is five clk_i cycles
`timescale 1ns/1ps
module io_channel_host_model (
   input wire clk_i,
   input wire sdo_i,
   output logic sclk_o,
   output logic sync_n_o,
   output logic sdi_o
);
   initial begin
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   task automatic frame(input int n, input logic [31:0] w, output logic [31:0] r);
      r = 32'h0;
      sync_n_o <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi_o <= (i < 32) ? w[31 - i] : 1'b0;
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b0;
         r = {r[30:0], sdo_i};
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b1;
      end
      repeat (5) @(posedge clk_i);
      sync_n_o <= 1'b1;
      // released data line does not hold its last value
      sdi_o <= ~sdi_o;
      repeat (12) @(posedge clk_i);
   endtask
endmodule // io_channel_host_model

// ===== test/io_channel_config_regs_tb.sv
// self-checking bench for the channel configuration register bank
// assumes the host model frames words as the bank expects
`timescale 1ns/1ps
module io_channel_config_regs_tb;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] pin_i = 4'h0;
   wire sclk_i, sync_n_i, sdi_i, sdo_o, boost_supply_en_o, frame_ignored_o;
   wire [3:0] pin_o, pin_oe_o, pin_pulldown_en_o;
   wire [15:0] channel_function_o, converter_settings_o, conversion_control_o;
   wire [15:0] diagnostic_source_select_o, output_code_live_o;
   int num_errors = 0;
   int comparisons = 0;
   int ignored = 0;
   int n;
   logic [31:0] junk;
   logic [23:0] rst_tab [21] = '{24'h000000, 24'h010000, 24'h022400, 24'h03001F, 24'h04000B,
      24'h050000, 24'h060000, 24'h070001, 24'h082E00, 24'h092E00, 24'h0A0000, 24'h0B0000,
      24'h0D0000, 24'h350008, 24'h360008, 24'h370008, 24'h380008, 24'h390000, 24'h3A0000,
      24'h3B0000, 24'h3C0000};
   logic [6:0] rw_tab [13] = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
      7'h0A, 7'h0B, 7'h3A, 7'h3B, 7'h3C};
   io_channel_config_regs uut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
      .sync_n_i(sync_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .pin_pulldown_en_o(pin_pulldown_en_o),
      .channel_function_o(channel_function_o), .converter_settings_o(converter_settings_o),
      .conversion_control_o(conversion_control_o), .boost_supply_en_o(boost_supply_en_o),
      .diagnostic_source_select_o(diagnostic_source_select_o),
      .output_code_live_o(output_code_live_o), .frame_ignored_o(frame_ignored_o));
   io_channel_host_model host (.clk_i(clk_i), .sdo_i(sdo_o), .sclk_o(sclk_i),
      .sync_n_o(sync_n_i), .sdi_o(sdi_i));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (frame_ignored_o === 1'b1)
         ignored++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host.frame(32, {1'b0, a, d, 8'h00}, junk);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      host.frame(32, {1'b1, a, 16'h0000, 8'h00}, junk);
      host.frame(32, 32'h0, junk);
      check(junk[23:8], exp);
   endtask
   task automatic complete_run;
      $display("Counts: %0d mismatches in %0d comparisons", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      foreach (rst_tab[i]) rd_chk(rst_tab[i][22:16], rst_tab[i][15:0]);
      wr(7'h00, 16'hFFFF);
      wr(7'h0D, 16'hFFFF);
      wr(7'h20, 16'hFFFF);
      rd_chk(7'h00, 16'h0000);
      rd_chk(7'h0D, 16'h0000);
      rd_chk(7'h20, 16'h0000);
      $display("reset and read-only test done");
      // converter set while conversion control is still zero
      foreach (rw_tab[i]) wr(rw_tab[i], 16'h5A3D);
      foreach (rw_tab[i]) rd_chk(rw_tab[i], 16'h5A3D);
      check(diagnostic_source_select_o, 16'h5A3D);
      check(conversion_control_o, 16'h5A3D);
      check({15'h0000, boost_supply_en_o}, 16'h0001);
      check(output_code_live_o, 16'h5A3D);
      check(converter_settings_o, 16'h5A3D);
      wr(7'h08, 16'h2E00); // switch outputs back off before function change
      wr(7'h09, 16'h2E00);
      wr(7'h39, 16'h5A3D); // leakage only while outputs are off
      rd_chk(7'h39, 16'h5A3D);
      wr(7'h39, 16'h0000);
      wr(7'h3B, 16'h0000);
      wr(7'h01, 16'h5A3D);
      check(channel_function_o, 16'h5A3D);
      check(converter_settings_o, 16'h2400);
      for (int i = 2; i < 8; i++) if (i != 3) rd_chk(7'(i), rst_tab[i][15:0]);
      rd_chk(7'h03, 16'h5A3D);
      rd_chk(7'h0B, 16'h5A3D);
      check(output_code_live_o, 16'h5A3D);
      wr(7'h01, 16'h0000);
      wr(7'h3A, 16'h0000);
      check({15'h0000, boost_supply_en_o}, 16'h0000);
      $display("register and function test done");
      pin_i <= 4'h5;
      for (int i = 0; i < 4; i++) wr(7'h35 + 7'(i), 16'hFFF1);
      for (int i = 0; i < 4; i++) rd_chk(7'h35 + 7'(i), {10'h000, pin_i[i], 5'h11});
      check({4'h0, pin_oe_o, pin_o, pin_pulldown_en_o}, 16'h0FF0);
      wr(7'h35, 16'h000A);
      check({4'h0, pin_oe_o, pin_o, pin_pulldown_en_o}, 16'h0EE1);
      $display("pin test done");
      host.frame(31, {1'b0, 7'h3C, 16'h1234, 8'h00}, junk);
      host.frame(33, {1'b0, 7'h3C, 16'h1234, 8'h00}, junk);
      rd_chk(7'h3C, 16'h5A3D);
      check(16'(ignored), 16'h0002);
      $display("frame length test done");
      wr(7'h06, 16'h0040);
      wr(7'h0B, 16'h5A40);
      n = 0;
      while (output_code_live_o !== 16'h5A40 && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      check({15'h0000, n > 150 && n < 350}, 16'h0001);
      $display("slew test done");
      complete_run;
   end
endmodule // io_channel_config_regs_tb
